// [src/adcc_top.v]
// adc conversion control: axi4-lite registers, start sequencing, results
// Function
// - 12-bit result held split in high and low result byte registers.
// - align 0 puts bits 11..4 high, 3..0 low upper; 1 right-justified.
// - result bits without data in chosen alignment read as zero.
// - results unchanged while converter enable is cleared.
// - start bit written high then low begins a conversion.
// - busy set when conversion starts, cleared when it completes.
// - busy flag read-only; writes to it have no effect.
// - enable bit turns converter on; cleared powers it down.
// - one shared core fed by channel and source selection mux.
// - 4-bit channel field bits 3..0; source field in second control.
// - first control register resets to all zeros.
// - bandgap control register holds the bandgap enable.
// - temperature control bit 0 enables sensor; bit 1 reserved.
// - read-only factory temperature result, left aligned.
// - channel codes 0..7 pick inputs; 8..15 pick no pin.
// - source codes map to external or internal; 111 leaves the source field unchanged.
// - clock divider codes give system clock over 1 to 128.
// - reference select 00 pin, 01 supply, 10 sensor, 11 supply.
`include "adcc_defs.vh"

module adcc_top #(
   parameter [11:0] FACTORY_TEMP_VAL = 12'h000, // arbitrary default
   parameter        CONV_CLKS        = `ADCC_CONV_CLKS
) (
   input  wire        I_REF_CLK,        // 125 mhz system clock
   input  wire        I_RST_N,          // async reset, active low
   input  wire [5:0]  I_AWADDR,         // write address
   input  wire        I_AWVALID,        // write address valid
   output wire        O_AWREADY,        // write address ready
   input  wire [31:0] I_WDATA,          // write data
   input  wire [3:0]  I_WSTRB,          // write strobes
   input  wire        I_WVALID,         // write data valid
   output wire        O_WREADY,         // write data ready
   output reg  [1:0]  O_BRESP,          // write response
   output reg         O_BVALID,         // write response valid
   input  wire        I_BREADY,         // write response ready
   input  wire [5:0]  I_ARADDR,         // read address
   input  wire        I_ARVALID,        // read address valid
   output wire        O_ARREADY,        // read address ready
   output reg  [31:0] O_RDATA,          // read data
   output reg  [1:0]  O_RRESP,          // read response
   output reg         O_RVALID,         // read data valid
   input  wire        I_RREADY,         // read data ready
   input  wire [7:0]  I_ANALOG_INPUTS,  // external input comparator bits
   input  wire        I_BANDGAP_CMP,    // bandgap comparator bit
   input  wire        I_TEMP_CMP,       // temp sensor comparator bit
   input  wire        I_AMP_OUT_CMP,    // amplifier output comparator bit
   input  wire        I_AMP_INP_CMP,    // amplifier input comparator bit
   output reg  [11:0] O_SAR_CODE,       // trial code to the dac
   output reg         O_CONV_POWER,     // converter powered
   output reg  [7:0]  O_EXT_CH_ONEHOT,  // external pin switches
   output reg  [2:0]  O_INT_SRC,        // internal source routing code
   output reg  [1:0]  O_REF_SELECT,     // reference voltage select
   output reg         O_BANDGAP_ON,     // bandgap reference enable
   output reg         O_TEMP_SENSOR_ON  // temperature sensor enable
);

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   reg        start_q;
   reg        busy_q;
   reg        enable_q;
   reg        align_q;
   reg [3:0]  channel_q;
   reg [2:0]  source_q;
   reg [1:0]  refsel_q;
   reg [2:0]  clkdiv_q;
   reg        temp_on_q;
   reg        temp_rsv_q;
   reg        bandgap_q;
   reg [7:0]  res_high_q;
   reg [7:0]  res_low_q;
   reg [6:0]  div_cnt_q;
   reg [3:0]  bit_idx_q;
   reg [11:0] sar_q;

   // -----------------------------------------------------------------
   // axi4-lite write channel
   // -----------------------------------------------------------------
   // both address and data must be present; one write at a time
   wire wr_go = I_AWVALID && I_WVALID && !O_BVALID;
   assign O_AWREADY = wr_go;
   assign O_WREADY  = wr_go;
   wire [7:0] wb = I_WDATA[7:0];
   wire       wlane = I_WSTRB[0];
   wire       wr_map = (I_AWADDR == `ADCC_OFS_RESULT_LOW) ||
                       (I_AWADDR == `ADCC_OFS_RESULT_HIGH) ||
                       (I_AWADDR == `ADCC_OFS_CTRL_FIRST) ||
                       (I_AWADDR == `ADCC_OFS_CTRL_SECOND) ||
                       (I_AWADDR == `ADCC_OFS_TEMP_CTRL) ||
                       (I_AWADDR == `ADCC_OFS_BANDGAP_CTRL) ||
                       (I_AWADDR == `ADCC_OFS_FTEMP_HIGH) ||
                       (I_AWADDR == `ADCC_OFS_FTEMP_LOW);
   wire wr_c0 = wr_go && wlane && (I_AWADDR == `ADCC_OFS_CTRL_FIRST);
   wire wr_c1 = wr_go && wlane && (I_AWADDR == `ADCC_OFS_CTRL_SECOND);
   wire wr_ts = wr_go && wlane && (I_AWADDR == `ADCC_OFS_TEMP_CTRL);
   wire wr_bg = wr_go && wlane && (I_AWADDR == `ADCC_OFS_BANDGAP_CTRL);

   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_BVALID <= 1'b0;
         O_BRESP  <= 2'h0;
      end else if (wr_go) begin
         O_BVALID <= 1'b1;
         O_BRESP  <= wr_map ? 2'h0 : 2'h2;
      end else if (I_BREADY) begin
         O_BVALID <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // start detection and control registers
   // -----------------------------------------------------------------
   wire start_new = wr_c0 ? wb[`ADCC_BIT_START] : start_q;
   // high-then-low on the start bit triggers
   wire start_seq = start_q && !start_new;
   wire conv_go   = start_seq && enable_q && !busy_q;
   wire conv_done;

   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         start_q    <= 1'b0;
         enable_q   <= 1'b0;
         align_q    <= 1'b0;
         channel_q  <= 4'h0;
         source_q   <= 3'h0;
         refsel_q   <= 2'h0;
         clkdiv_q   <= 3'h0;
         temp_on_q  <= 1'b0;
         temp_rsv_q <= 1'b1;
         bandgap_q  <= `ADCC_RST_BANDGAP;
      end else begin
         if (wr_c0) begin
            // busy bit position ignored on writes
            start_q   <= wb[`ADCC_BIT_START];
            enable_q  <= wb[`ADCC_BIT_ENABLE];
            align_q   <= wb[`ADCC_BIT_ALIGN];
            channel_q <= wb[3:0];
         end
         if (wr_c1) begin
            if (wb[7:5] != `ADCC_SRC_FORBIDDEN)
               source_q <= wb[7:5];
            refsel_q <= wb[4:3];
            clkdiv_q <= wb[2:0];
         end
         if (wr_ts) begin
            temp_on_q  <= wb[0];
            temp_rsv_q <= wb[1];
         end
         if (wr_bg)
            bandgap_q <= wb[0];
      end
   end

   // -----------------------------------------------------------------
   // conversion clock divider and successive approximation
   // -----------------------------------------------------------------
   // comparator chosen by source then channel; floating pins compare low
   reg cmp_sel;
   always @* begin
      case (source_q)
         `ADCC_SRC_BANDGAP: cmp_sel = I_BANDGAP_CMP;
         `ADCC_SRC_TEMP:    cmp_sel = I_TEMP_CMP;
         `ADCC_SRC_AMP_OUT: cmp_sel = I_AMP_OUT_CMP;
         `ADCC_SRC_AMP_INP: cmp_sel = I_AMP_INP_CMP;
         default: cmp_sel = channel_q[3] ? 1'b0 :
                            I_ANALOG_INPUTS[channel_q[2:0]];
      endcase
   end

   wire [6:0] div_last = (7'h01 << clkdiv_q) - 7'h01;
   wire       tick     = (div_cnt_q == div_last);
   // one conversion: 12 bit trials plus settle clocks, counted in ticks
   localparam [3:0] LAST_IDX = 4'd11;
   localparam integer SETTLE_N = CONV_CLKS - 12;
   localparam [4:0] SETTLE_CLKS = SETTLE_N[4:0];
   reg [4:0] settle_q;
   wire      trial = busy_q && tick && (settle_q == 5'h00);
   assign conv_done = trial && (bit_idx_q == 4'h0);
   wire [11:0] final_code = sar_q & ~(12'h001 << bit_idx_q) |
                           ({11'h000, cmp_sel} << bit_idx_q);
   wire [11:0] sar_next = final_code | ((bit_idx_q != 4'h0) ?
                          (12'h001 << (bit_idx_q - 4'h1)) : 12'h000);

   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         busy_q    <= 1'b0;
         div_cnt_q <= 7'h00;
         bit_idx_q <= 4'h0;
         sar_q     <= 12'h000;
         O_SAR_CODE <= 12'h000;
         settle_q  <= 5'h00;
      end else if (conv_go) begin
         busy_q    <= 1'b1;
         div_cnt_q <= 7'h00;
         bit_idx_q <= LAST_IDX;
         sar_q     <= 12'h800;
         // trial code leaves with sar_q so the comparator sees it in time
         O_SAR_CODE <= 12'h800;
         settle_q  <= SETTLE_CLKS;
      end else if (busy_q) begin
         div_cnt_q <= tick ? 7'h00 : div_cnt_q + 7'h01;
         if (!enable_q) begin
            // power-down aborts; results untouched
            busy_q <= 1'b0;
         end else if (tick && settle_q != 5'h00) begin
            settle_q <= settle_q - 5'h01;
         end else if (trial) begin
            sar_q      <= sar_next;
            O_SAR_CODE <= sar_next;
            if (conv_done)
               busy_q <= 1'b0;
            else
               bit_idx_q <= bit_idx_q - 4'h1;
         end
      end
   end

   // -----------------------------------------------------------------
   // result registers
   // -----------------------------------------------------------------
   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         res_high_q <= 8'h00;
         res_low_q  <= 8'h00;
      end else if (conv_done && enable_q) begin
         if (!align_q) begin
            res_high_q <= final_code[11:4];
            res_low_q  <= {final_code[3:0], 4'h0};
         end else begin
            res_high_q <= {4'h0, final_code[11:8]};
            res_low_q  <= final_code[7:0];
         end
      end
   end

   // -----------------------------------------------------------------
   // analog side outputs
   // -----------------------------------------------------------------
   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_CONV_POWER     <= 1'b0;
         O_EXT_CH_ONEHOT  <= 8'h00;
         O_INT_SRC        <= 3'h0;
         O_REF_SELECT     <= 2'h0;
         O_BANDGAP_ON     <= 1'b0;
         O_TEMP_SENSOR_ON <= 1'b0;
      end else begin
         O_CONV_POWER     <= enable_q;
         O_EXT_CH_ONEHOT  <= channel_q[3] ? 8'h00 :
                             (8'h01 << channel_q[2:0]);
         O_INT_SRC        <= source_q;
         O_REF_SELECT     <= refsel_q;
         O_BANDGAP_ON     <= bandgap_q;
         O_TEMP_SENSOR_ON <= temp_on_q;
      end
   end

   // -----------------------------------------------------------------
   // axi4-lite read channel
   // -----------------------------------------------------------------
   assign O_ARREADY = !O_RVALID;
   reg [7:0] rd_byte;
   reg       rd_ok;
   always @* begin
      rd_ok = 1'b1;
      case (I_ARADDR)
         `ADCC_OFS_RESULT_LOW:   rd_byte = res_low_q;
         `ADCC_OFS_RESULT_HIGH:  rd_byte = res_high_q;
         `ADCC_OFS_CTRL_FIRST:   rd_byte = {start_q, busy_q, enable_q,
                                            align_q, channel_q};
         `ADCC_OFS_CTRL_SECOND:  rd_byte = {source_q, refsel_q, clkdiv_q};
         `ADCC_OFS_TEMP_CTRL:    rd_byte = {6'h00, temp_rsv_q, temp_on_q};
         `ADCC_OFS_BANDGAP_CTRL: rd_byte = {7'h00, bandgap_q};
         `ADCC_OFS_FTEMP_HIGH:   rd_byte = FACTORY_TEMP_VAL[11:4];
         `ADCC_OFS_FTEMP_LOW:    rd_byte = {FACTORY_TEMP_VAL[3:0], 4'h0};
         default: begin
            rd_byte = 8'h00;
            rd_ok   = 1'b0;
         end
      endcase
   end

   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_RVALID <= 1'b0;
         O_RDATA  <= 32'h0000_0000;
         O_RRESP  <= 2'h0;
      end else if (I_ARVALID && !O_RVALID) begin
         O_RVALID <= 1'b1;
         O_RDATA  <= {24'h000000, rd_byte};
         O_RRESP  <= rd_ok ? 2'h0 : 2'h2;
      end else if (I_RREADY) begin
         O_RVALID <= 1'b0;
      end
   end

endmodule // adcc_top

// [common/adcc_defs.vh]
// register map, field positions, reset values and timing for adc control
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH

// -----------------------------------------------------------------
// register byte addresses
// -----------------------------------------------------------------
`define ADCC_OFS_RESULT_LOW    6'h00
`define ADCC_OFS_RESULT_HIGH   6'h04
`define ADCC_OFS_CTRL_FIRST    6'h08
`define ADCC_OFS_CTRL_SECOND   6'h0c
`define ADCC_OFS_TEMP_CTRL     6'h10
`define ADCC_OFS_BANDGAP_CTRL  6'h14
`define ADCC_OFS_FTEMP_HIGH    6'h18
`define ADCC_OFS_FTEMP_LOW     6'h1c

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define ADCC_BIT_START         7
`define ADCC_BIT_BUSY          6
`define ADCC_BIT_ENABLE        5
`define ADCC_BIT_ALIGN         4
`define ADCC_SRC_FORBIDDEN     3'h7
`define ADCC_SRC_BANDGAP       3'h1
`define ADCC_SRC_TEMP          3'h2
`define ADCC_SRC_AMP_OUT       3'h3
`define ADCC_SRC_AMP_INP       3'h4

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define ADCC_RST_CTRL_FIRST    8'h00
`define ADCC_RST_CTRL_SECOND   8'h00
`define ADCC_RST_TEMP_CTRL     2'h2
`define ADCC_RST_BANDGAP       1'b0

// -----------------------------------------------------------------
// timing: conversion clocks per conversion
// -----------------------------------------------------------------
`define ADCC_CONV_CLKS         16

`endif

// [sim/adcc_monitor.sv]
// checker of bus handshakes and control outputs of the adc control block
module adcc_monitor (
   input wire        I_REF_CLK,       // clock
   input wire        I_RST_N,         // reset, active low
   input wire [5:0]  I_AWADDR,        // write address
   input wire        I_AWVALID,       // write address valid
   input wire [31:0] I_WDATA,         // write data
   input wire [3:0]  I_WSTRB,         // write strobes
   input wire        I_WVALID,        // write data valid
   input wire        O_AWREADY,       // write address ready
   input wire [1:0]  O_BRESP,         // write response
   input wire        O_BVALID,        // write response valid
   input wire        I_BREADY,        // write response ready
   input wire        I_ARVALID,       // read address valid
   input wire        O_ARREADY,       // read address ready
   input wire [31:0] O_RDATA,         // read data
   input wire        O_RVALID,        // read valid
   input wire        I_RREADY,        // read ready
   input wire        O_CONV_POWER,    // converter powered
   input wire        O_BANDGAP_ON,    // bandgap enable
   input wire [7:0]  O_EXT_CH_ONEHOT  // pin switches
);
   timeunit 1ns;
   timeprecision 1ps;
   wire wr_any  = I_AWVALID & I_WVALID & O_AWREADY & ~O_BVALID;
   wire wr_take = wr_any & I_WSTRB[0];
   reg  pw_q;
   reg  bg_q;
   // expected levels, latched when the write is taken
   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         pw_q <= 1'b0;
         bg_q <= 1'b0;
      end else if (wr_take) begin
         if (I_AWADDR == 6'h08) pw_q <= I_WDATA[5];
         if (I_AWADDR == 6'h14) bg_q <= I_WDATA[0];
      end
   end
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_N);
   write_answer_a: assert property (wr_any |=> O_BVALID)
      else $error("write not answered");
   bresp_hold_a: assert property (O_BVALID && !I_BREADY |=>
      O_BVALID && $stable(O_BRESP)) else $error("write response dropped");
   read_answer_a: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
      else $error("read not answered");
   rdata_hold_a: assert property (O_RVALID && !I_RREADY |=>
      O_RVALID && $stable(O_RDATA)) else $error("read data dropped");
   rdata_upper_a: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h000000)
      else $error("upper read bits set");
   pin_onehot_a: assert property ($onehot0(O_EXT_CH_ONEHOT))
      else $error("several pins switched");
   power_follow_a: assert property (wr_take && I_AWADDR == 6'h08 |->
      ##[1:2] O_CONV_POWER == pw_q) else $error("power wrong");
   bandgap_follow_a: assert property (wr_take && I_AWADDR == 6'h14 |->
      ##[1:2] O_BANDGAP_ON == bg_q) else $error("bandgap wrong");
endmodule // adcc_monitor

bind adcc_top adcc_monitor u_mon (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N),
   .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID), .I_WDATA(I_WDATA),
   .I_WSTRB(I_WSTRB), .I_WVALID(I_WVALID), .O_AWREADY(O_AWREADY),
   .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
   .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
   .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_CONV_POWER(O_CONV_POWER),
   .O_BANDGAP_ON(O_BANDGAP_ON), .O_EXT_CH_ONEHOT(O_EXT_CH_ONEHOT));

// [sim/adcc_analog_model.sv]
// comparator model of the analog inputs and internal sources
module adcc_analog_model #(
   parameter [11:0] EXT_BASE = 12'h0c3, // level of pin 0
   parameter [11:0] EXT_STEP = 12'h1d1, // step between pins
   parameter [11:0] BG_VAL   = 12'h5a3, // bandgap level
   parameter [11:0] TS_VAL   = 12'h3c7, // sensor level
   parameter [11:0] AO_VAL   = 12'h9e1, // amplifier output level
   parameter [11:0] AI_VAL   = 12'h2b4  // amplifier input level
) (
   input  wire        i_clk,  // clock
   input  wire [11:0] i_code, // trial code
   input  wire [7:0]  i_sel,  // pin switches
   output reg  [7:0]  o_ext,  // pin comparators
   output wire        o_bg,   // bandgap comparator
   output wire        o_ts,   // sensor comparator
   output wire        o_ao,   // amplifier output comparator
   output wire        o_ai    // amplifier input comparator
);
   timeunit 1ns;
   timeprecision 1ps;
   reg     tg_q = 1'b0;
   integer k;
   always @(posedge i_clk) tg_q <= ~tg_q;
   // unswitched pins toggle so a wrong mux never reads a steady value
   always @* begin
      for (k = 0; k < 8; k = k + 1)
         o_ext[k] = i_sel[k] ? (EXT_BASE + EXT_STEP * k >= i_code) : tg_q ^ k[0];
   end
   assign o_bg = BG_VAL >= i_code;
   assign o_ts = TS_VAL >= i_code;
   assign o_ao = AO_VAL >= i_code;
   assign o_ai = AI_VAL >= i_code;
endmodule // adcc_analog_model

// [sim/tb.sv]
// self-checking bench for the adc conversion control block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [11:0] EB = 12'h0c3, ES = 12'h1d1, BG = 12'h5a3;
   localparam [11:0] TS = 12'h3c7, AO = 12'h9e1, AI = 12'h2b4;
   reg         clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   reg         bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   reg  [5:0]  awaddr = 6'h00, araddr = 6'h00;
   reg  [31:0] wdata = 32'h0, rv;
   reg  [1:0]  resp;
   wire        awready, wready, bvalid, arready, rvalid, bg_c, ts_c;
   wire        ao_c, ai_c, pwr, bg_on, ts_on;
   wire [1:0]  bresp, rresp, ref_sel;
   wire [31:0] rdata;
   wire [7:0]  ext_in, onehot;
   wire [11:0] code;
   wire [2:0]  int_src;
   reg  [5:0]  ra [0:6] = '{6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h20};
   reg  [7:0]  re [0:6] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h7c, 8'h40, 8'h00};
   reg  [11:0] iv [0:4] = '{12'h0, BG, TS, AO, AI};
   integer     n_errors = 0, check_count = 0, i;

   adcc_top #(.FACTORY_TEMP_VAL(12'h7c4)) dut (.I_REF_CLK(clk), .I_RST_N(rst_n),
      .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
      .I_WDATA(wdata), .I_WSTRB(4'h1), .I_WVALID(wvalid), .O_WREADY(wready),
      .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
      .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
      .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
      .I_ANALOG_INPUTS(ext_in), .I_BANDGAP_CMP(bg_c), .I_TEMP_CMP(ts_c),
      .I_AMP_OUT_CMP(ao_c), .I_AMP_INP_CMP(ai_c), .O_SAR_CODE(code),
      .O_CONV_POWER(pwr), .O_EXT_CH_ONEHOT(onehot), .O_INT_SRC(int_src),
      .O_REF_SELECT(ref_sel), .O_BANDGAP_ON(bg_on), .O_TEMP_SENSOR_ON(ts_on));
   adcc_analog_model #(.EXT_BASE(EB), .EXT_STEP(ES), .BG_VAL(BG),
      .TS_VAL(TS), .AO_VAL(AO), .AI_VAL(AI)) u_ana (.i_clk(clk),
      .i_code(code), .i_sel(onehot), .o_ext(ext_in), .o_bg(bg_c),
      .o_ts(ts_c), .o_ao(ao_c), .o_ai(ai_c));

   initial forever #4 clk = ~clk;
   initial begin
      #400000;
      n_errors = n_errors + 1;
      tally_and_finish;
   end
   // -----------------------------------------------------------------
   // bus tasks
   // -----------------------------------------------------------------
   task chk(input [31:0] seen, input [31:0] exp, input [63:0] what);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task wr(input [5:0] a, input [7:0] d);
      begin
         @(posedge clk);
         awaddr <= a;
         wdata <= {24'h000000, d};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         do @(posedge clk); while (awready !== 1'b1);
         awvalid <= 1'b0;
         wvalid <= 1'b0;
         bready <= 1'b1;
         do @(posedge clk); while (bvalid !== 1'b1);
         resp = bresp;
         bready <= 1'b0;
         // outputs launched at the response edge settle before callers look
         @(negedge clk);
      end
   endtask
   task rd(input [5:0] a);
      begin
         @(posedge clk);
         araddr <= a;
         arvalid <= 1'b1;
         do @(posedge clk); while (arready !== 1'b1);
         arvalid <= 1'b0;
         rready <= 1'b1;
         do @(posedge clk); while (rvalid !== 1'b1);
         rv = rdata;
         resp = rresp;
         rready <= 1'b0;
      end
   endtask
   task start(input [7:0] c1);
      begin
         wr(6'h08, c1 | 8'h80);
         wr(6'h08, c1);
      end
   endtask
   task conv(input [7:0] c2, input [7:0] c1);
      begin
         wr(6'h0c, c2);
         start(c1);
         rd(6'h08);
         chk(rv[6], 1'b1, "busy");
         do rd(6'h08); while (rv[6] !== 1'b0);
      end
   endtask
   task res(input [11:0] v, input al);
      begin
         rd(6'h04);
         chk(rv, al ? {28'h0, v[11:8]} : {24'h0, v[11:4]}, "high");
         rd(6'h00);
         chk(rv, al ? {24'h0, v[7:0]} : {24'h0, v[3:0], 4'h0}, "low");
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", check_count, n_errors);
         if (n_errors == 0 && check_count > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   // -----------------------------------------------------------------
   // tests
   // -----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 7; i = i + 1) begin
         rd(ra[i]);
         chk(rv, re[i], "regreset");
      end
      chk(resp, 2'b10, "rresp");
      $display("test reset values done");
      conv(8'h00, 8'h23);
      res(EB + ES * 3, 1'b0);
      conv(8'h00, 8'h33);
      res(EB + ES * 3, 1'b1);
      conv(8'ha0, 8'h27);
      res(EB + ES * 7, 1'b0);
      conv(8'h00, 8'h29);
      res(12'h000, 1'b0);
      for (i = 1; i < 5; i = i + 1) begin
         conv(i << 5, 8'h28);
         res(iv[i], 1'b0);
      end
      $display("test conversions done");
      for (i = 0; i < 4; i = i + 1) begin
         wr(6'h0c, 8'h20 | (i << 3));
         chk(ref_sel, i[1:0], "refsel");
      end
      wr(6'h0c, 8'hfc);
      rd(6'h0c);
      chk(rv, 32'h3c, "srcbad");
      chk(int_src, 32'h1, "intsrc");
      $display("test second control done");
      start(8'h21);
      repeat (90) @(posedge clk);
      rd(6'h08);
      chk(rv, 32'h61, "slowbusy");
      wr(6'h08, 8'h01);
      chk(pwr, 1'b0, "power");
      res(AI, 1'b0);
      start(8'h01);
      rd(6'h08);
      chk(rv, 32'h01, "offstart");
      res(AI, 1'b0);
      wr(6'h08, 8'h60);
      rd(6'h08);
      chk(rv, 32'h20, "busywr");
      $display("test enable and busy done");
      wr(6'h0c, 8'h00);
      start(8'h22);
      start(8'h22);
      do rd(6'h08); while (rv[6] !== 1'b0);
      res(EB + ES * 2, 1'b0);
      wr(6'h14, 8'h01);
      chk(resp, 2'b00, "bresp");
      chk(bg_on, 1'b1, "bgap");
      wr(6'h10, 8'h03);
      rd(6'h10);
      chk({ts_on, rv[7:0]}, 9'h103, "tsensor");
      $display("test restart and sources done");
      tally_and_finish;
   end
endmodule // tb
